// >>> src/rac_pkg.sv
// Package for the alarm and interrupt control block: register map, fields, reset values.
// Assumes a byte-wide register port addressed by the device's own register pointer.
package rac_pkg;
	localparam logic [3:0] ADDR_A1_SEC = 4'h7;
	localparam logic [3:0] ADDR_A1_MIN = 4'h8;
	localparam logic [3:0] ADDR_A1_HOUR = 4'h9;
	localparam logic [3:0] ADDR_A1_DAY = 4'hA;
	localparam logic [3:0] ADDR_A2_MIN = 4'hB;
	localparam logic [3:0] ADDR_A2_HOUR = 4'hC;
	localparam logic [3:0] ADDR_A2_DAY = 4'hD;
	localparam logic [3:0] ADDR_RTC_CONTROL = 4'hE;
	localparam logic [3:0] ADDR_RTC_FLAGS = 4'hF;
	localparam int BIT_MASK = 7;
	localparam int BIT_DAYSEL = 6;
	localparam int BIT_OSC_DIS_N = 7;
	localparam int BIT_RATE_HI = 4;
	localparam int BIT_RATE_LO = 3;
	localparam int BIT_ROUTING = 2;
	localparam int BIT_A2_IE = 1;
	localparam int BIT_A1_IE = 0;
	localparam int BIT_OSF = 7;
	localparam int BIT_A2_FLAG = 1;
	localparam int BIT_A1_FLAG = 0;
	localparam logic [7:0] CONTROL_WMASK = 8'h9F;
	localparam logic [7:0] CONTROL_RESET = 8'h18;
	localparam logic [7:0] FLAGS_RESET = 8'h80;
	localparam logic [7:0] ALARM_RESET = 8'h00;
	localparam logic [5:0] DAYDATE_FIELD = 6'h3F;
	localparam logic [6:0] SEC_FIELD = 7'h7F;
	// Square-wave reference: tick rate is 32.768 kHz; divide exponents below
	localparam int SQW_DIV_1HZ = 15;
	localparam int SQW_DIV_4K = 3;
	localparam int SQW_DIV_8K = 2;
	localparam int SQW_DIV_32K = 0;
endpackage : rac_pkg

// >>> src/rac_alarm_match.sv
// One alarm comparator, parameterised for the seconds-less second alarm.
// Assumes BCD time inputs stable while sec_tick is high.
`timescale 1ns/1ps
module rac_alarm_match
	import rac_pkg::*;
#(
	parameter bit HAS_SEC = 1'b1
) (
	input wire logic [6:0] now_sec,
	input wire logic [6:0] now_min,
	input wire logic [6:0] now_hour,
	input wire logic [2:0] now_day,
	input wire logic [5:0] now_date,
	input wire logic [7:0] al_sec,
	input wire logic [7:0] al_min,
	input wire logic [7:0] al_hour,
	input wire logic [7:0] al_day,
	output logic hit
);
	logic sec_ok;
	logic min_ok;
	logic hour_ok;
	logic day_ok;
	logic [5:0] day_val;
	always_comb begin
		// BCD fields compared bitwise, no conversion needed
		day_val = al_day[BIT_DAYSEL] ? {3'b000, now_day} : now_date;
		if (HAS_SEC) begin
			sec_ok = al_sec[BIT_MASK] || (al_sec[6:0] == now_sec);
		end else begin
			sec_ok = (now_sec == 7'h00); // Fixed 00 seconds
		end
		min_ok = al_min[BIT_MASK] || (al_min[6:0] == now_min);
		hour_ok = al_hour[BIT_MASK] || (al_hour[6:0] == now_hour);
		day_ok = al_day[BIT_MASK] || ((al_day[5:0] & DAYDATE_FIELD) == day_val);
		hit = sec_ok && min_ok && hour_ok && day_ok;
	end
endmodule : rac_alarm_match

// >>> src/rac_alarm_ctrl.sv
// Alarm compare, flags, interrupt routing and square-wave output of a serial RTC.
// Assumes the serial engine gives a byte register port and the calendar a 1 s update strobe.
`timescale 1ns/1ps
module rac_alarm_ctrl
	import rac_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sec_tick,
	input wire logic tick_32k,
	input wire logic osc_fail,
	input wire logic [6:0] now_sec,
	input wire logic [6:0] now_min,
	input wire logic [6:0] now_hour,
	input wire logic [2:0] now_day,
	input wire logic [5:0] now_date,
	output logic osc_run,
	output logic irq_out_primary_n,
	output logic squarewave_or_irq_out_n
);
	logic [7:0] a1_sec;
	logic [7:0] a1_min;
	logic [7:0] a1_hour;
	logic [7:0] a1_day;
	logic [7:0] a2_min;
	logic [7:0] a2_hour;
	logic [7:0] a2_day;
	logic oscillator_disable_n;
	logic rate_select_high;
	logic rate_select_low;
	logic interrupt_routing_select;
	logic alarm_two_irq_enable;
	logic alarm_one_irq_enable;
	logic osc_stopped_flag;
	logic alarm_one_flag;
	logic alarm_two_flag;
	logic a1_hit;
	logic a2_hit;
	logic [14:0] sqw_div;
	logic sqw_level;
	logic next_primary_n;
	logic next_second_n;
	logic wr_ctl;
	logic wr_flg;

	assign wr_ctl = reg_wr && (reg_addr == ADDR_RTC_CONTROL);
	assign wr_flg = reg_wr && (reg_addr == ADDR_RTC_FLAGS);

	rac_alarm_match #(.HAS_SEC(1'b1)) u_match_one (
		.now_sec(now_sec),
		.now_min(now_min),
		.now_hour(now_hour),
		.now_day(now_day),
		.now_date(now_date),
		.al_sec(a1_sec),
		.al_min(a1_min),
		.al_hour(a1_hour),
		.al_day(a1_day),
		.hit(a1_hit)
	);

	rac_alarm_match #(.HAS_SEC(1'b0)) u_match_two (
		.now_sec(now_sec),
		.now_min(now_min),
		.now_hour(now_hour),
		.now_day(now_day),
		.now_date(now_date),
		.al_sec(ALARM_RESET),
		.al_min(a2_min),
		.al_hour(a2_hour),
		.al_day(a2_day),
		.hit(a2_hit)
	);

	// Alarm compare registers
	always_ff @(posedge clk) begin
		if (rst) begin
			a1_sec <= ALARM_RESET;
			a1_min <= ALARM_RESET;
			a1_hour <= ALARM_RESET;
			a1_day <= ALARM_RESET;
			a2_min <= ALARM_RESET;
			a2_hour <= ALARM_RESET;
			a2_day <= ALARM_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_A1_SEC: a1_sec <= reg_wdata;
				ADDR_A1_MIN: a1_min <= reg_wdata;
				ADDR_A1_HOUR: a1_hour <= reg_wdata;
				ADDR_A1_DAY: a1_day <= reg_wdata;
				ADDR_A2_MIN: a2_min <= reg_wdata;
				ADDR_A2_HOUR: a2_hour <= reg_wdata;
				ADDR_A2_DAY: a2_day <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Control register
	always_ff @(posedge clk) begin
		if (rst) begin
			oscillator_disable_n <= CONTROL_RESET[BIT_OSC_DIS_N];
			rate_select_high <= CONTROL_RESET[BIT_RATE_HI];
			rate_select_low <= CONTROL_RESET[BIT_RATE_LO];
			interrupt_routing_select <= CONTROL_RESET[BIT_ROUTING];
			alarm_two_irq_enable <= CONTROL_RESET[BIT_A2_IE];
			alarm_one_irq_enable <= CONTROL_RESET[BIT_A1_IE];
		end else if (wr_ctl) begin
			oscillator_disable_n <= reg_wdata[BIT_OSC_DIS_N];
			rate_select_high <= reg_wdata[BIT_RATE_HI];
			rate_select_low <= reg_wdata[BIT_RATE_LO];
			interrupt_routing_select <= reg_wdata[BIT_ROUTING];
			alarm_two_irq_enable <= reg_wdata[BIT_A2_IE];
			alarm_one_irq_enable <= reg_wdata[BIT_A1_IE];
		end
	end

	// Oscillator run output follows the active-low enable
	always_ff @(posedge clk) begin
		if (rst) begin
			osc_run <= 1'b1;
		end else begin
			osc_run <= ~oscillator_disable_n;
		end
	end

	// Sticky flags; a set in the clearing cycle wins so no event is lost
	always_ff @(posedge clk) begin
		if (rst) begin
			osc_stopped_flag <= FLAGS_RESET[BIT_OSF];
		end else if (oscillator_disable_n || osc_fail) begin
			osc_stopped_flag <= 1'b1;
		end else if (wr_flg && !reg_wdata[BIT_OSF]) begin
			osc_stopped_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_one_flag <= FLAGS_RESET[BIT_A1_FLAG];
		end else if (sec_tick && a1_hit) begin
			alarm_one_flag <= 1'b1;
		end else if (wr_flg && !reg_wdata[BIT_A1_FLAG]) begin
			alarm_one_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_two_flag <= FLAGS_RESET[BIT_A2_FLAG];
		end else if (sec_tick && a2_hit) begin
			alarm_two_flag <= 1'b1;
		end else if (wr_flg && !reg_wdata[BIT_A2_FLAG]) begin
			alarm_two_flag <= 1'b0;
		end
	end

	// Square-wave divider off the 32.768 kHz tick; stalls with the oscillator
	always_ff @(posedge clk) begin
		if (rst) begin
			sqw_div <= 15'h0000;
		end else if (tick_32k && !oscillator_disable_n) begin
			sqw_div <= sqw_div + 15'h0001;
		end
	end

	always_comb begin
		unique case ({rate_select_high, rate_select_low})
			2'b00: sqw_level = sqw_div[SQW_DIV_1HZ - 1];
			2'b01: sqw_level = sqw_div[SQW_DIV_4K - 1];
			2'b10: sqw_level = sqw_div[SQW_DIV_8K - 1];
			2'b11: sqw_level = tick_32k;
		endcase
	end

	always_comb begin
		next_primary_n = ~((alarm_one_flag && alarm_one_irq_enable) ||
			(alarm_two_flag && alarm_two_irq_enable && !interrupt_routing_select));
		if (interrupt_routing_select) begin
			next_second_n = ~(alarm_two_flag && alarm_two_irq_enable);
		end else begin
			next_second_n = sqw_level;
		end
	end

	// Registered pins; one cycle behind the flags
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_out_primary_n <= 1'b1;
			squarewave_or_irq_out_n <= 1'b1;
		end else begin
			irq_out_primary_n <= next_primary_n;
			squarewave_or_irq_out_n <= next_second_n;
		end
	end

	// Read port, one-cycle latency; unused bits read 0
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_A1_SEC: reg_rdata <= a1_sec;
				ADDR_A1_MIN: reg_rdata <= a1_min;
				ADDR_A1_HOUR: reg_rdata <= a1_hour;
				ADDR_A1_DAY: reg_rdata <= a1_day;
				ADDR_A2_MIN: reg_rdata <= a2_min;
				ADDR_A2_HOUR: reg_rdata <= a2_hour;
				ADDR_A2_DAY: reg_rdata <= a2_day;
				ADDR_RTC_CONTROL: reg_rdata <= {oscillator_disable_n, 2'b00, rate_select_high,
					rate_select_low, interrupt_routing_select, alarm_two_irq_enable,
					alarm_one_irq_enable};
				ADDR_RTC_FLAGS: reg_rdata <= {osc_stopped_flag, 5'b00000, alarm_two_flag,
					alarm_one_flag};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule : rac_alarm_ctrl

// >>> verif/rac_alarm_ctrl_sva.sv
// Port checker for the alarm control block.
// Assumes rac_pkg is compiled first; bound to every rac_alarm_ctrl.
`timescale 1ns/1ps
module rac_alarm_ctrl_sva
	import rac_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic sec_tick,
	input wire logic tick_32k,
	input wire logic osc_fail,
	input wire logic [6:0] now_sec,
	input wire logic [6:0] now_min,
	input wire logic [6:0] now_hour,
	input wire logic [2:0] now_day,
	input wire logic [5:0] now_date,
	input wire logic osc_run,
	input wire logic irq_out_primary_n,
	input wire logic squarewave_or_irq_out_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_reset_idle: assert property (disable iff (1'b0)
		rst |=> osc_run && irq_out_primary_n && squarewave_or_irq_out_n) else $error("outputs busy after reset");
	a_osc_ctrl: assert property (
		reg_wr && reg_addr == ADDR_RTC_CONTROL |=> ##1 osc_run == !$past(reg_wdata[7], 2)) else $error("osc enable wrong");
	a_irq_fall: assert property (
		$fell(irq_out_primary_n) |-> $past(sec_tick, 2) || $past(reg_wr, 2)) else $error("irq without cause");
	a_irq_rise: assert property ($rose(irq_out_primary_n) |-> $past(reg_wr, 2))
		else $error("irq released alone");
	a_time_zero: assert property (reg_rd && reg_addr < ADDR_A1_SEC |=> reg_rdata == 8'h00)
		else $error("time range not zero");
	a_flags_resv: assert property (reg_rd && reg_addr == ADDR_RTC_FLAGS |=> reg_rdata[6:2] == 5'h00)
		else $error("flag spare bits set");
	a_ctrl_resv: assert property (reg_rd && reg_addr == ADDR_RTC_CONTROL |=> reg_rdata[6:5] == 2'h0)
		else $error("control spare bits set");
	a_osf_set: assert property (reg_rd && reg_addr == ADDR_RTC_FLAGS && !osc_run |=> reg_rdata[7])
		else $error("stop flag clear while stopped");
	c_irq_low: cover property ($fell(irq_out_primary_n));
	c_wave_irq: cover property ($fell(squarewave_or_irq_out_n));
	c_osf_read: cover property (reg_rd && reg_addr == ADDR_RTC_FLAGS && !osc_run);
endmodule : rac_alarm_ctrl_sva
bind rac_alarm_ctrl rac_alarm_ctrl_sva chk_i (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
	.sec_tick, .tick_32k, .osc_fail, .now_sec, .now_min, .now_hour, .now_day, .now_date, .osc_run,
	.irq_out_primary_n, .squarewave_or_irq_out_n);

// >>> verif/rac_host.sv
// Host model driving the byte register port.
// Assumes one clock; requests change just after a rising edge.
`timescale 1ns/1ps
module rac_host (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	// Released lines show inverted values, never a stale copy
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b0, ~a};
		#1 d = reg_rdata;
	endtask : rd
endmodule : rac_host

// >>> verif/test_rtc_alarm_interrupt_control.sv
// Bench for the alarm control block: registers, alarm matching, pin routing.
// Assumes rac_host drives registers; calendar values and ticks come from here.
`timescale 1ns/1ps
module test_rtc_alarm_interrupt_control;
	import rac_pkg::*;
	logic clk = 0, rst = 1, sec_tick = 0, tick_32k = 0, osc_fail = 0, osc_run, pa_n, pb_n, reg_wr, reg_rd;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v;
	logic [6:0] now_sec = 0, now_min = 0, now_hour = 0;
	logic [2:0] now_day = 0;
	logic [5:0] now_date = 0;
	logic [1:0] dv = 0;
	int n_fail = 0, cmp_count = 0;
	rac_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
	rac_alarm_ctrl uut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sec_tick, .tick_32k,
		.osc_fail, .now_sec, .now_min, .now_hour, .now_day, .now_date, .osc_run, .irq_out_primary_n(pa_n),
		.squarewave_or_irq_out_n(pb_n));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Fast tick: one pulse in four cycles keeps wave checks short
	always @(posedge clk) begin
		dv <= dv + 2'h1;
		tick_32k <= dv == 2'h0;
	end
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic rdc(logic [3:0] a, logic [7:0] e);
		host.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask : rdc
	task automatic tick(logic [6:0] s, m, h, logic [2:0] d, logic [7:0] e);
		@(posedge clk);
		{now_sec, now_min, now_hour, now_day, now_date, sec_tick} <= {s, m, h, d, 6'h10, 1'b1};
		@(posedge clk);
		sec_tick <= 1'b0;
		rdc(ADDR_RTC_FLAGS, e);
	endtask : tick
	task automatic a1(int n, logic [7:0] e);
		tick(n > 0 ? 7'h30 : 7'h31, n > 1 ? 7'h15 : 7'h16, n > 2 ? 7'h12 : 7'h13, n > 3 ? 3'h5 : 3'h6, e);
	endtask : a1
	task automatic pins(logic [7:0] c, logic [1:0] e, logic [1:0] m);
		host.wr(ADDR_RTC_CONTROL, c);
		repeat (2) @(posedge clk);
		#1 chk("pins", {6'h00, e}, {6'h00, {pa_n, pb_n} & m});
	endtask : pins
	// Settle two cycles first so a mode change is not counted as a rise
	task automatic rises(int n, logic [7:0] e);
		int r = 0;
		logic p;
		repeat (2) @(posedge clk);
		#1 p = pb_n;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1 r += (pb_n && !p);
			p = pb_n;
		end
		chk("wave rises", e, r[7:0]);
	endtask : rises
	task automatic t_reset();
		rdc(ADDR_RTC_CONTROL, 8'h18);
		rdc(ADDR_RTC_FLAGS, 8'h80);
		rdc(ADDR_A1_SEC, 8'h00);
		rdc(4'h3, 8'h00);
		rises(16, 8'h04);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_regs();
		host.wr(ADDR_RTC_CONTROL, 8'hFF);
		rdc(ADDR_RTC_CONTROL, 8'h9F);
		chk("osc_run", 8'h00, {7'h00, osc_run});
		host.wr(ADDR_RTC_FLAGS, 8'h00);
		rdc(ADDR_RTC_FLAGS, 8'h80);
		host.wr(ADDR_RTC_CONTROL, 8'h05);
		host.wr(ADDR_RTC_FLAGS, 8'hFF);
		rdc(ADDR_RTC_FLAGS, 8'h80);
		host.wr(ADDR_RTC_FLAGS, 8'h00);
		rdc(ADDR_RTC_FLAGS, 8'h00);
		@(posedge clk);
		osc_fail <= 1'b1;
		@(posedge clk);
		osc_fail <= 1'b0;
		rdc(ADDR_RTC_FLAGS, 8'h80);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_alarm1();
		logic [7:0] al [4] = '{8'h30, 8'h15, 8'h12, 8'h45};
		for (int k = 0; k < 5; k++) begin
			for (int j = 0; j < 4; j++) begin
				host.wr(ADDR_A1_SEC + 4'(j), al[j] | (j >= k ? 8'h80 : 8'h00));
			end
			host.wr(ADDR_RTC_FLAGS, 8'h00);
			if (k > 0) a1(k - 1, 8'h00);
			a1(k, 8'h01);
		end
		rdc(ADDR_A1_DAY, 8'h45);
		host.wr(ADDR_A1_DAY, 8'h10);
		host.wr(ADDR_RTC_FLAGS, 8'h00);
		a1(3, 8'h01);
		$display("t_alarm1 done");
	endtask : t_alarm1
	task automatic t_alarm2();
		logic [7:0] al [3] = '{8'h15, 8'h12, 8'h45};
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 3; j++) begin
				host.wr(ADDR_A2_MIN + 4'(j), al[j] | (j >= k ? 8'h80 : 8'h00));
			end
			host.wr(ADDR_RTC_FLAGS, 8'h00);
			tick(k == 0 ? 7'h30 : 7'h00, k > 1 ? 7'h15 : 7'h16, k > 2 ? 7'h12 : 7'h13, 3'h6, 8'h00);
			tick(7'h00, k > 0 ? 7'h15 : 7'h16, k > 1 ? 7'h12 : 7'h13, k > 2 ? 3'h5 : 3'h6, 8'h02);
		end
		$display("t_alarm2 done");
	endtask : t_alarm2
	task automatic t_pins();
		pins(8'h02, 2'h0, 2'h2);
		pins(8'h06, 2'h2, 2'h3);
		pins(8'h04, 2'h3, 2'h3);
		a1(3, 8'h03);
		pins(8'h04, 2'h3, 2'h3);
		pins(8'h05, 2'h1, 2'h3);
		host.wr(ADDR_RTC_FLAGS, 8'h02);
		rdc(ADDR_RTC_FLAGS, 8'h02);
		pins(8'h05, 2'h3, 2'h3);
		$display("t_pins done");
	endtask : t_pins
	// Bench tick is one pulse in four cycles: 64 cycles hold 16 ticks
	task automatic t_wave();
		host.wr(ADDR_RTC_CONTROL, 8'h00);
		rises(64, 8'h00);
		host.wr(ADDR_RTC_CONTROL, 8'h08);
		rises(64, 8'h02);
		host.wr(ADDR_RTC_CONTROL, 8'h10);
		rises(64, 8'h04);
		host.wr(ADDR_RTC_CONTROL, 8'h18);
		rises(64, 8'h10);
		$display("t_wave done");
	endtask : t_wave
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_alarm1();
		t_alarm2();
		t_pins();
		t_wave();
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		wrap_up();
	end
endmodule : test_rtc_alarm_interrupt_control
